// ### tb/emif16_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module emif16_port_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Memory, arbitration and byte order pins
   input wire logic [3:0] chip_enable_n,
   input wire logic [1:0] byte_lane_enables_n,
   input wire logic shared_output_enable_n,
   input wire logic shared_write_strobe_n,
   input wire logic fifo_space_output_enable_n,
   input wire logic host_bus_request_in_n,
   input wire logic host_bus_grant_out_n,
   input wire logic device_bus_request_out,
   input wire logic little_endian
);
   logic [1:0] age_reg;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Edges seen since reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) age_reg <= 2'h0;
      else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
   end
   AST_ONE_CE: assert property ($onehot0(~chip_enable_n))
      else $error("more than one chip enable");
   AST_BE_CE: assert property (byte_lane_enables_n != 2'h3 |-> chip_enable_n != 4'hF)
      else $error("byte lane outside access");
   AST_OE_CE: assert property (!shared_output_enable_n |-> chip_enable_n != 4'hF)
      else $error("output enable outside access");
   AST_WR_CE: assert property (!shared_write_strobe_n |-> chip_enable_n != 4'hF)
      else $error("write strobe outside access");
   AST_FIFO_OE: assert property (!fifo_space_output_enable_n |-> !chip_enable_n[3])
      else $error("fifo enable outside third space");
   AST_GRANT_REQ: assert property ($fell(host_bus_grant_out_n) |-> !host_bus_request_in_n)
      else $error("grant without request");
   AST_GRANT_QUIET: assert property (!host_bus_grant_out_n |-> chip_enable_n == 4'hF)
      else $error("bus driven while granted");
   AST_GRANT_DROP: assert property ($rose(host_bus_request_in_n) |-> ##[0:3] host_bus_grant_out_n)
      else $error("grant kept after request");
   AST_BUSREQ_ACT: assert property (chip_enable_n != 4'hF |-> device_bus_request_out)
      else $error("bus request low during access");
   AST_STRAP_HOLD: assert property (age_reg == 2'h3 |-> $stable(little_endian))
      else $error("byte order moved");
endmodule : emif16_port_monitor
bind emif16_port emif16_port_monitor emif16_port_monitor_i (.pclk, .presetn, .chip_enable_n,
   .byte_lane_enables_n, .shared_output_enable_n, .shared_write_strobe_n,
   .fifo_space_output_enable_n, .host_bus_request_in_n, .host_bus_grant_out_n,
   .device_bus_request_out, .little_endian);
`default_nettype wire

// ### tb/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model #(
   parameter int WAIT_CYCLES = 6
) (
   input wire logic pclk,
   input wire logic [3:0] chip_enable_n,
   output logic async_ready_in
);
   int cnt = 0;
   // Slow memory: not ready for a span after select, pulled up when idle
   always @(posedge pclk) begin
      if (&chip_enable_n) cnt <= 0;
      else if (cnt < WAIT_CYCLES) cnt <= cnt + 1;
   end
   assign async_ready_in = (&chip_enable_n) || (cnt >= WAIT_CYCLES);
endmodule : ext_mem_model
`default_nettype wire

// ### tb/test_emif16_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_emif16_port;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, ext = 1'b0, full, divd, oe_n, rdy, req_n = 1'b1, gnt_n;
   logic busreq, le, rs_n, soe_n, ws_n, fifo_n, pdt_n, pf, pd, clr = 1'b0;
   logic [19:0] straps = 20'h0, addr_out, a_seen;
   logic [1:0] be_n, b_seen;
   logic [3:0] ce_n, c_seen;
   logic [2:0] ph = 3'h0;
   int errors = 0, num_checks = 0, rd_low, wr_low, ff_low, fr, dr, oe_low, pt_low;
   wire [19:0] pins = oe_n ? straps : addr_out;
   always #25 pclk = ~pclk;
   emif16_port emif16_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .iface_ext_clock_in(ext), .iface_clock_out_full(full),
      .iface_clock_out_divided(divd), .addr_in(pins), .addr_out, .addr_oe_n(oe_n),
      .byte_lane_enables_n(be_n), .chip_enable_n(ce_n), .shared_read_strobe_n(rs_n),
      .shared_output_enable_n(soe_n), .shared_write_strobe_n(ws_n),
      .fifo_space_output_enable_n(fifo_n), .peripheral_direct_transfer_n(pdt_n),
      .async_ready_in(rdy), .host_bus_request_in_n(req_n), .host_bus_grant_out_n(gnt_n),
      .device_bus_request_out(busreq), .little_endian(le));
   ext_mem_model ext_mem_model_i (.pclk, .chip_enable_n(ce_n), .async_ready_in(rdy));
   // Interface clock source and pin activity counters
   always @(posedge pclk) begin
      ph <= ph + 3'h1;
      ext <= ph[2];
      pf <= full;
      pd <= divd;
      if (clr) begin
         {rd_low, wr_low, ff_low, fr, dr, oe_low, pt_low} <= '0;
      end else begin
         fr <= fr + int'(full && !pf);
         dr <= dr + int'(divd && !pd);
         rd_low <= rd_low + int'(!rs_n);
         wr_low <= wr_low + int'(!ws_n);
         ff_low <= ff_low + int'(!fifo_n);
         oe_low <= oe_low + int'(!soe_n);
         pt_low <= pt_low + int'(!pdt_n);
      end
      if (ce_n != 4'hF) begin
         c_seen <= ce_n;
         a_seen <= addr_out;
         b_seen <= be_n;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic chk_near(input int got, input int exp, input string msg);
      num_checks++;
      if (got < exp - 1 || got > exp + 1) begin
         errors++;
         $display("CHECK FAILED %0t %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask : chk_near
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rst(input logic [19:0] s);
      presetn <= 1'b0;
      straps <= s;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      straps <= ~s;
   endtask : rst
   task automatic acc(input logic [31:0] word);
      int n;
      n = 0;
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      apb(1'b1, 12'h008, word);
      repeat (3) @(posedge pclk);
      do begin
         apb(1'b0, 12'h00C, 32'h0);
         n++;
      end while (rd !== 32'h1 && n < 40);
      chk(rd, 32'h0000_0001, "access end");
   endtask : acc
   task automatic end_of_test;
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial begin
      logic [1:0] k;
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         rst({k[0], 4'h0, k, 13'h0});
         apb(1'b0, 12'h010, 32'h0);
         chk(rd, {28'h0, 1'b1, k[0], (k == 2'h3) ? 2'h0 : k}, "strap");
         chk(le, k[0], "byte order");
         clr <= 1'b1;
         @(posedge pclk);
         clr <= 1'b0;
         repeat (48) @(posedge pclk);
         chk_near(fr, (k == 2'h1) ? 12 : (k == 2'h2) ? 8 : 6, "source clock");
      end
      apb(1'b0, 12'h020, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000, "unmapped");
      apb(1'b1, 12'h004, 32'h0000_0880);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000_0880, "space readback");
      acc(32'h9401_2345);
      chk(c_seen, 4'hE, "space 0 select");
      chk(a_seen, 20'h12345, "address");
      chk(b_seen, 2'h2, "lanes");
      chk(wr_low > 0, 1, "write strobe");
      chk(ff_low, 0, "fifo enable");
      chk(oe_low, 0, "no output enable");
      chk(pt_low, 0, "no direct transfer");
      acc(32'h8C01_2345);
      chk(rd_low >= 6, 1, "ready stretch");
      chk(wr_low, 0, "no write");
      chk(oe_low > 0, 1, "output enable");
      acc(32'h8F00_0040);
      chk(c_seen, 4'h7, "space 3 select");
      chk(ff_low > 0, 1, "fifo enable");
      chk(rd_low > 0, 1, "read enable");
      apb(1'b1, 12'h004, 32'h0000_0084);
      acc(32'h9500_0010);
      chk(c_seen, 4'hD, "space 1 select");
      chk(b_seen, 2'h2, "sdram mask");
      chk(oe_low > 0, 1, "row strobe");
      chk(rd_low > 0, 1, "column strobe");
      acc(32'h9F00_0040);
      chk(rd_low > 0, 1, "address strobe");
      chk(ff_low, 0, "fifo enable on write");
      chk(oe_low, 0, "output enable on write");
      req_n <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(gnt_n, 0, "grant");
      chk(ce_n, 4'hF, "bus released");
      req_n <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(gnt_n, 1, "grant dropped");
      chk(busreq, 0, "no bus request");
      apb(1'b1, 12'h000, 32'h0000_000E);
      repeat (2) @(posedge pclk);
      chk(busreq, 1, "bus request");
      acc(32'h8C01_2345);
      chk(pt_low > 0, 1, "direct transfer");
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (128) @(posedge pclk);
      chk_near(fr, 16, "full clock");
      chk_near(dr, 4, "divided clock");
      end_of_test();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      end_of_test();
   end
endmodule : test_emif16_port
`default_nettype wire

// ### verilog/emif16_pkg.sv
package emif16_pkg;
   typedef enum logic [1:0] {
      MEM_ASYNC = 2'h0,
      MEM_SDRAM = 2'h1,
      MEM_SYNC = 2'h2
   } mem_type_t;
   typedef enum logic [1:0] {
      CLK_EXT = 2'h0,
      CLK_DIV4 = 2'h1,
      CLK_DIV6 = 2'h2
   } clk_src_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_STROBE = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_HOLD = 4'b1000
   } state_t;
endpackage : emif16_pkg

// ### verilog/emif16_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "emif16_regs.svh"
module emif16_port
   import emif16_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock sources
   input wire logic iface_ext_clock_in,
   output logic iface_clock_out_full,
   output logic iface_clock_out_divided,
   // Address pins, two-way, enable low while driving
   input wire logic [ADDR_W-1:0] addr_in,
   output logic [ADDR_W-1:0] addr_out,
   output logic addr_oe_n,
   // Memory control
   output logic [1:0] byte_lane_enables_n,
   output logic [3:0] chip_enable_n,
   output logic shared_read_strobe_n,
   output logic shared_output_enable_n,
   output logic shared_write_strobe_n,
   output logic fifo_space_output_enable_n,
   output logic peripheral_direct_transfer_n,
   input wire logic async_ready_in,
   // Arbitration
   input wire logic host_bus_request_in_n,
   output logic host_bus_grant_out_n,
   output logic device_bus_request_out,
   // Strapped byte order
   output logic little_endian
);
   logic [31:0] ctrl_reg;
   logic [31:0] space_reg;
   logic [31:0] acc_reg;
   logic go_reg;
   logic straps_taken_reg;
   logic [1:0] clk_src_reg;
   state_t state_reg;
   logic [3:0] cnt_reg;
   logic [2:0] div_cnt_reg;
   logic src_clk_reg;
   logic src_prev_reg;
   logic [1:0] div2_reg;
   logic src_rise;
   logic [1:0] acc_space;
   mem_type_t acc_type;
   logic acc_rsel;
   logic acc_write;
   logic apb_wr;
   logic [1:0] div_sel;
   logic apb_take;
   logic [1:0] strap_clk_code;
   logic access_active;
   logic read_strobe_on;
   logic output_enable_on;
   logic fifo_enable_on;

   assign apb_wr = psel & penable & pwrite;
   assign acc_space = acc_reg[`ACC_SPACE_LSB +: 2];
   assign acc_type = mem_type_t'(space_reg[{acc_space, 1'b0} +: 2]);
   assign acc_rsel = space_reg[`SPACE_RSEL_LSB + {30'h0, acc_space}];
   assign acc_write = acc_reg[`ACC_WRITE_BIT];
   assign div_sel = ctrl_reg[`CTRL_DIV_LSB +: 2];
   assign apb_take = apb_wr & pready;
   assign strap_clk_code = addr_in[`STRAP_CLK_LSB +: 2];

   // APB read side and handshake, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            unique case (paddr)
               `OFF_CTRL: prdata <= ctrl_reg;
               `OFF_SPACE: prdata <= space_reg;
               `OFF_ACCESS: prdata <= acc_reg;
               `OFF_STATUS: prdata <= {28'h0, state_reg};
               `OFF_STRAP: prdata <= {28'h0, straps_taken_reg, little_endian, clk_src_reg};
               default: begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // APB writes land at the edge that completes the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CTRL_RESET;
         space_reg <= `SPACE_RESET;
         acc_reg <= 32'h0000_0000;
      end else if (apb_take) begin
         if (paddr == `OFF_CTRL) ctrl_reg <= pwdata;
         if (paddr == `OFF_SPACE) space_reg <= pwdata;
         // Access word is frozen while the sequencer uses it
         if (paddr == `OFF_ACCESS && state_reg == ST_IDLE) acc_reg <= pwdata;
      end
   end

   // Access launch pulse; set wins over the clear by the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_reg <= 1'b0;
      end else if (apb_wr && pready && paddr == `OFF_ACCESS && pwdata[`ACC_GO_BIT]
                   && state_reg == ST_IDLE) begin
         go_reg <= 1'b1;
      end else if (state_reg == ST_STROBE) begin
         go_reg <= 1'b0;
      end
   end

   // Straps sampled once after reset release, held until next reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         straps_taken_reg <= 1'b0;
         clk_src_reg <= CLK_EXT;
         little_endian <= 1'b1;
      end else if (!straps_taken_reg) begin
         straps_taken_reg <= 1'b1;
         little_endian <= addr_in[`STRAP_ENDIAN_BIT];
         clk_src_reg <= (strap_clk_code == 2'h3) ? CLK_EXT : strap_clk_code;
      end
   end

   // Source clock generation: external pin sampled, or pclk divided by 4 or 6
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= 3'h0;
         src_clk_reg <= 1'b0;
         src_prev_reg <= 1'b0;
      end else begin
         src_prev_reg <= src_clk_reg;
         unique case (clk_src_reg)
            CLK_DIV4: begin
               div_cnt_reg <= (div_cnt_reg >= 3'h1) ? 3'h0 : div_cnt_reg + 3'h1;
               if (div_cnt_reg >= 3'h1) src_clk_reg <= ~src_clk_reg;
            end
            CLK_DIV6: begin
               div_cnt_reg <= (div_cnt_reg >= 3'h2) ? 3'h0 : div_cnt_reg + 3'h1;
               if (div_cnt_reg >= 3'h2) src_clk_reg <= ~src_clk_reg;
            end
            default: begin
               div_cnt_reg <= 3'h0;
               src_clk_reg <= iface_ext_clock_in;
            end
         endcase
      end
   end
   assign src_rise = src_clk_reg & ~src_prev_reg;

   // Divider for the second output clock, counts source rising edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div2_reg <= 2'h0;
      end else if (src_rise) begin
         div2_reg <= div2_reg + 2'h1;
      end
   end

   // Output clocks: full rate and programmable divide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iface_clock_out_full <= 1'b0;
         iface_clock_out_divided <= 1'b0;
      end else begin
         iface_clock_out_full <= src_clk_reg;
         unique case (div_sel)
            2'h1: iface_clock_out_divided <= div2_reg[0];
            2'h2: iface_clock_out_divided <= div2_reg[1];
            default: iface_clock_out_divided <= src_clk_reg;
         endcase
      end
   end

   // Strobe length counter, reloaded while idle so every access starts full
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
      end else if (state_reg == ST_IDLE) begin
         cnt_reg <= `STROBE_CYCLES;
      end else if (state_reg == ST_STROBE && cnt_reg > 4'h1) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end

   // Access sequencer and bus hold arbitration; host hold beats a pending access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (!host_bus_request_in_n) begin
                  state_reg <= ST_HOLD;
               end else if (go_reg && straps_taken_reg) begin
                  state_reg <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (cnt_reg <= 4'h1) state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (acc_type != MEM_ASYNC || async_ready_in) state_reg <= ST_IDLE;
            end
            ST_HOLD: begin
               if (host_bus_request_in_n) state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Sequencer is driving the external bus
   assign access_active = (state_reg == ST_STROBE) || (state_reg == ST_WAIT);
   // Role of each shared pin: column strobe and address strobe act on writes too
   assign read_strobe_on = !acc_write || acc_type == MEM_SDRAM
      || (acc_type == MEM_SYNC && !acc_rsel);
   assign output_enable_on = !acc_write || acc_type == MEM_SDRAM;
   assign fifo_enable_on = !acc_write && acc_space == 2'h3 && acc_type == MEM_SYNC;

   // Address pins stay inputs until straps taken, off during hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_out <= '0;
         addr_oe_n <= 1'b1;
      end else begin
         addr_oe_n <= ~straps_taken_reg || (state_reg == ST_HOLD);
         addr_out <= acc_reg[`ACC_ADDR_LSB +: ADDR_W];
      end
   end

   // Byte lanes and chip enables, levels for the whole access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_lane_enables_n <= 2'h3;
         chip_enable_n <= 4'hF;
      end else begin
         byte_lane_enables_n <= access_active ? ~acc_reg[`ACC_BE_LSB +: 2] : 2'h3;
         chip_enable_n <= access_active ? ~(4'h1 << acc_space) : 4'hF;
      end
   end

   // Shared strobes, one level per access with no per-cycle timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_read_strobe_n <= 1'b1;
         shared_output_enable_n <= 1'b1;
         shared_write_strobe_n <= 1'b1;
         fifo_space_output_enable_n <= 1'b1;
      end else begin
         shared_read_strobe_n <= ~(access_active && read_strobe_on);
         shared_output_enable_n <= ~(access_active && output_enable_on);
         shared_write_strobe_n <= ~(access_active && acc_write);
         fifo_space_output_enable_n <= ~(access_active && fifo_enable_on);
      end
   end

   // Peripheral transfer and arbitration outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_direct_transfer_n <= 1'b1;
         host_bus_grant_out_n <= 1'b1;
         device_bus_request_out <= 1'b0;
      end else begin
         peripheral_direct_transfer_n <= ~(access_active && ctrl_reg[`CTRL_PDT_BIT]);
         host_bus_grant_out_n <= ~(state_reg == ST_HOLD);
         device_bus_request_out <= go_reg || access_active
            || ctrl_reg[`CTRL_BUSREQ_BIT];
      end
   end
endmodule : emif16_port
`default_nettype wire

// ### verilog/emif16_regs.svh
`ifndef EMIF16_REGS_SVH
`define EMIF16_REGS_SVH
// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_SPACE 12'h004
`define OFF_ACCESS 12'h008
`define OFF_STATUS 12'h00C
`define OFF_STRAP 12'h010
// Control register fields
`define CTRL_DIV_LSB 0
`define CTRL_BUSREQ_BIT 2
`define CTRL_PDT_BIT 3
`define CTRL_RESET 32'h0000_0000
// Space config: two bits of memory type per space, read strobe select per space
`define SPACE_TYPE_LSB 0
`define SPACE_RSEL_LSB 8
`define SPACE_RESET 32'h0000_0000
// Access register fields
`define ACC_ADDR_LSB 0
`define ACC_SPACE_LSB 24
`define ACC_BE_LSB 26
`define ACC_WRITE_BIT 28
`define ACC_GO_BIT 31
// Strap pin positions on the address bus
`define STRAP_ENDIAN_BIT 19
`define STRAP_CLK_LSB 13
// Access strobe length in clocks
`define STROBE_CYCLES 4'h3
`endif
